/* File: bmr_consts.vh */
// Purpose: Constants for the bit manipulation and rotate-through-carry unit
// Assumes: Plain Verilog-2005, included by bare name
// Notes: Operation codes, size codes, field widths and reset values of the unit
// How it works
// - Rotate B/W/L one place through carry
// - Bit number from immediate or register
// - Force selected byte bit to one
// - Force selected byte bit to zero
// - Invert selected byte bit, write back
// - Carry ANDed with selected bit
// - Carry ANDed with inverted bit
// - Carry ORed with selected bit
// - Carry ORed with inverted bit
// - Inverted combines use immediate bit only
`ifndef BMR_CONSTS_VH
`define BMR_CONSTS_VH

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define BMR_OP_ROTL 4'h0
`define BMR_OP_ROTR 4'h1
`define BMR_OP_FONE 4'h2
`define BMR_OP_FZERO 4'h3
`define BMR_OP_INV 4'h4
`define BMR_OP_PROBE 4'h5
`define BMR_OP_CAND 4'h6
`define BMR_OP_CANDI 4'h7
`define BMR_OP_COR 4'h8
`define BMR_OP_CORI 4'h9

// ----------------------------------------
// Operand sizes
// ----------------------------------------
`define BMR_SZ_BYTE 2'h0
`define BMR_SZ_WORD 2'h1
`define BMR_SZ_LONG 2'h2

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define BMR_BITNUM_W 3
`define BMR_BYTE_MSB 7
`define BMR_WORD_MSB 15
`define BMR_LONG_MSB 31
`define BMR_RST_DATA 32'h00000000
`define BMR_RST_FLAG 1'h0
`define BMR_RST_ADDR 16'h0000
`define BMR_RST_BYTE 8'h00
`define BMR_RST_OP 4'h0
`define BMR_RST_BIT 3'h0

`endif

/* File: bmr_bit_alu.v */
// Purpose: Combinational bit engine for one byte operand
// Assumes: Operation codes from the constants header
// Notes: No state; the top registers every result
`timescale 1ns/1ps
`default_nettype none
`include "bmr_consts.vh"

module bmr_bit_alu (
  input wire [3:0] opCode,
  input wire [7:0] byteIn,
  input wire [2:0] bitNum,
  input wire carryIn,
  output reg [7:0] byteOut,
  output reg carryOut,
  output reg zeroOut,
  output reg byteWrite,
  output reg carryWrite,
  output reg zeroWrite
);

  // Selected operand bit
  wire selBit;
  assign selBit = byteIn[bitNum];

  // ----------------------------------------
  // Bit operation decode
  // ----------------------------------------
  always @* begin
    byteOut = byteIn;
    carryOut = carryIn;
    zeroOut = 1'b0;
    byteWrite = 1'b0;
    carryWrite = 1'b0;
    zeroWrite = 1'b0;
    case (opCode)
      `BMR_OP_FONE: begin
        byteOut[bitNum] = 1'b1;
        byteWrite = 1'b1;
      end
      `BMR_OP_FZERO: begin
        byteOut[bitNum] = 1'b0;
        byteWrite = 1'b1;
      end
      `BMR_OP_INV: begin
        byteOut[bitNum] = ~selBit;
        byteWrite = 1'b1;
      end
      `BMR_OP_PROBE: begin
        // Operand untouched, only Z moves
        zeroOut = ~selBit;
        zeroWrite = 1'b1;
      end
      `BMR_OP_CAND: begin
        carryOut = carryIn & selBit;
        carryWrite = 1'b1;
      end
      `BMR_OP_CANDI: begin
        carryOut = carryIn & ~selBit;
        carryWrite = 1'b1;
      end
      `BMR_OP_COR: begin
        carryOut = carryIn | selBit;
        carryWrite = 1'b1;
      end
      `BMR_OP_CORI: begin
        carryOut = carryIn | ~selBit;
        carryWrite = 1'b1;
      end
      default: begin
        // Rotates and unknown codes: nothing here
        byteOut = byteIn;
      end
    endcase
  end

endmodule
`default_nettype wire

/* File: bmr_unit.v */
// Purpose: Bit manipulation and rotate-through-carry execution unit
// Assumes: Decoder holds operands stable while opValid is high
// Notes: One registered result per accepted operation; memory bytes
//   are read through a request/answer pair before write-back
//   Busy refuses new requests until the read answer arrives
`timescale 1ns/1ps
`default_nettype none
`include "bmr_consts.vh"

module bmr_unit (
  input wire clk_sys,
  input wire sys_rst,
  input wire opValid,
  input wire [3:0] opCode,
  input wire [1:0] opSize,
  input wire opIsMem,
  input wire useRegBitNum,
  input wire [2:0] immBitNum,
  input wire [31:0] bitNumReg,
  input wire [31:0] regOperand,
  input wire [15:0] memAddr,
  input wire carryIn,
  input wire memRdValid,
  input wire [7:0] memRdData,
  output reg opBusy_r,
  output reg opDone_r,
  output reg [31:0] regResult_r,
  output reg regWrite_r,
  output reg carryResult_r,
  output reg carryWrite_r,
  output reg zeroResult_r,
  output reg zeroWrite_r,
  output reg memRdReq_r,
  output reg memWrReq_r,
  output reg [15:0] memAddr_r,
  output reg [7:0] memWrData_r
);

  // ----------------------------------------
  // State machine codes
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_MEMRD = 2'h1;

  reg [1:0] state_r; // Current state
  reg [1:0] stateNxt; // Next state
  reg [3:0] heldOp_r; // Opcode kept across a memory read
  reg [2:0] heldBit_r; // Bit number kept across a memory read
  reg heldCarry_r; // Carry kept across a memory read

  // ----------------------------------------
  // Rotate helper: one place through carry
  // ----------------------------------------
  // Byte and word results clear the upper bits, trading register
  // merge logic for a simpler datapath; carry out rides in bit 32
  function [32:0] rotThruCarry;
    input [31:0] val;
    input [1:0] sz;
    input dirRight;
    input cin;
    reg [32:0] res;
    begin
      res = {1'b0, val};
      case (sz)
        `BMR_SZ_BYTE: begin
          if (dirRight) res = {val[0], 24'h000000, cin, val[7:1]};
          else res = {val[7], 24'h000000, val[6:0], cin};
        end
        `BMR_SZ_WORD: begin
          if (dirRight) res = {val[0], 16'h0000, cin, val[15:1]};
          else res = {val[15], 16'h0000, val[14:0], cin};
        end
        default: begin
          if (dirRight) res = {val[0], cin, val[31:1]};
          else res = {val[31], val[30:0], cin};
        end
      endcase
      rotThruCarry = res;
    end
  endfunction

  // ----------------------------------------
  // Bit number selection
  // ----------------------------------------
  // Inverted combines ignore the register source entirely
  wire invCombine;
  assign invCombine = (opCode == `BMR_OP_CANDI) || (opCode == `BMR_OP_CORI);
  wire [2:0] bitSel;
  assign bitSel = (useRegBitNum && !invCombine) ? bitNumReg[2:0] : immBitNum;

  // Accepted operation and its kind
  // New work is refused while a memory read is open
  wire accept;
  assign accept = opValid && (state_r == ST_IDLE);
  // Rotates never take the memory path, even with opIsMem set
  wire isRotate;
  assign isRotate = (opCode == `BMR_OP_ROTL) || (opCode == `BMR_OP_ROTR);

  // ----------------------------------------
  // Bit engine on register or memory byte
  // ----------------------------------------
  wire inMem;
  assign inMem = (state_r == ST_MEMRD);
  wire [3:0] aluOp;
  assign aluOp = inMem ? heldOp_r : opCode;
  wire [7:0] aluByte;
  assign aluByte = inMem ? memRdData : regOperand[7:0];
  wire [2:0] aluBit;
  assign aluBit = inMem ? heldBit_r : bitSel;
  wire aluCin;
  assign aluCin = inMem ? heldCarry_r : carryIn;
  wire [7:0] aluByteOut;
  wire aluCout, aluZout, aluByteWr, aluCarryWr, aluZeroWr;

  // One bit engine serves register bytes and memory bytes alike
  bmr_bit_alu uAlu (
    .opCode(aluOp),
    .byteIn(aluByte),
    .bitNum(aluBit),
    .carryIn(aluCin),
    .byteOut(aluByteOut),
    .carryOut(aluCout),
    .zeroOut(aluZout),
    .byteWrite(aluByteWr),
    .carryWrite(aluCarryWr),
    .zeroWrite(aluZeroWr)
  );

  // Rotate result: carry out in bit 32, register value below
  wire [32:0] rotRes;
  assign rotRes = rotThruCarry(regOperand, opSize, opCode == `BMR_OP_ROTR, carryIn);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    stateNxt = state_r;
    case (state_r)
      ST_IDLE: begin
        // Memory operand needs its byte first
        if (accept && opIsMem && !isRotate) stateNxt = ST_MEMRD;
      end
      ST_MEMRD: begin
        // No time limit: only the answer or a reset leaves this state
        if (memRdValid) stateNxt = ST_IDLE;
      end
      default: begin
        stateNxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registered results and memory requests
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      // Every output and held field back to its idle value
      state_r <= ST_IDLE;
      heldOp_r <= `BMR_RST_OP;
      heldBit_r <= `BMR_RST_BIT;
      heldCarry_r <= `BMR_RST_FLAG;
      opBusy_r <= 1'b0;
      opDone_r <= 1'b0;
      regResult_r <= `BMR_RST_DATA;
      regWrite_r <= 1'b0;
      carryResult_r <= `BMR_RST_FLAG;
      carryWrite_r <= 1'b0;
      zeroResult_r <= `BMR_RST_FLAG;
      zeroWrite_r <= 1'b0;
      memRdReq_r <= 1'b0;
      memWrReq_r <= 1'b0;
      memAddr_r <= `BMR_RST_ADDR;
      memWrData_r <= `BMR_RST_BYTE;
    end else begin
      state_r <= stateNxt;
      // Pulses default low
      opDone_r <= 1'b0;
      regWrite_r <= 1'b0;
      carryWrite_r <= 1'b0;
      zeroWrite_r <= 1'b0;
      memRdReq_r <= 1'b0;
      memWrReq_r <= 1'b0;
      opBusy_r <= (stateNxt != ST_IDLE);
      if (accept && isRotate) begin
        // Rotates act on registers only
        regResult_r <= rotRes[31:0];
        carryResult_r <= rotRes[32];
        regWrite_r <= 1'b1;
        carryWrite_r <= 1'b1;
        opDone_r <= 1'b1;
      end else if (accept && opIsMem) begin
        // Hold the operation and ask for the byte
        heldOp_r <= opCode;
        heldBit_r <= bitSel;
        // Carry frozen now, so the late answer combines the old flag
        heldCarry_r <= carryIn;
        memAddr_r <= memAddr;
        memRdReq_r <= 1'b1;
      end else if (accept) begin
        // Register byte: upper bits pass untouched
        regResult_r <= {regOperand[31:8], aluByteOut};
        regWrite_r <= aluByteWr;
        carryResult_r <= aluCout;
        carryWrite_r <= aluCarryWr;
        zeroResult_r <= aluZout;
        zeroWrite_r <= aluZeroWr;
        opDone_r <= 1'b1;
      end else if (inMem && memRdValid) begin
        // Whole byte written back at the same address
        memWrData_r <= aluByteOut;
        // Probe and carry ops only read; their write strobe stays low
        memWrReq_r <= aluByteWr;
        carryResult_r <= aluCout;
        carryWrite_r <= aluCarryWr;
        zeroResult_r <= aluZout;
        zeroWrite_r <= aluZeroWr;
        opDone_r <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: bmr_unit_props.sv */
// Purpose: Port checks for bmr_unit
// Assumes: One clock, sync reset
// Notes: Expected values from helper nets
`timescale 1ns/1ps
`default_nettype none
module bmr_unit_props (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic opValid,
  input wire logic [3:0] opCode,
  input wire logic [1:0] opSize,
  input wire logic opIsMem,
  input wire logic useRegBitNum,
  input wire logic [2:0] immBitNum,
  input wire logic [31:0] bitNumReg,
  input wire logic [31:0] regOperand,
  input wire logic [15:0] memAddr,
  input wire logic carryIn,
  input wire logic memRdValid,
  input wire logic opBusy_r,
  input wire logic opDone_r,
  input wire logic [31:0] regResult_r,
  input wire logic regWrite_r,
  input wire logic carryResult_r,
  input wire logic carryWrite_r,
  input wire logic zeroResult_r,
  input wire logic zeroWrite_r,
  input wire logic memRdReq_r,
  input wire logic [15:0] memAddr_r
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Chosen bit, and the immediate-only bit of the inverted combines
  wire [2:0] sel = useRegBitNum ? bitNumReg[2:0] : immBitNum;
  wire bSel = regOperand[sel];
  wire bImm = regOperand[immBitNum];
  wire [7:0] msk = 8'h01 << sel;
  wire take = opValid && !opBusy_r;
  wire regOp = take && (!opIsMem || opCode < 4'h2);
  wire memOp = take && opIsMem && opCode > 4'h1 && opCode < 4'hA;
  wire [7:0] bExp = opCode == 4'h2 ? regOperand[7:0] | msk :
    opCode == 4'h3 ? regOperand[7:0] & ~msk : regOperand[7:0] ^ msk;
  wire cExp = opCode == 4'h6 ? carryIn & bSel : opCode == 4'h7 ? carryIn & ~bImm :
    opCode == 4'h8 ? carryIn | bSel : carryIn | ~bImm;
  wire [7:0] rExp = opCode[0] ? {carryIn, regOperand[7:1]} : {regOperand[6:0], carryIn};
  wire rC = opCode[0] ? regOperand[0] : regOperand[7];
  property p_done; regOp |=> opDone_r && !opBusy_r; endproperty
  a_done: assert property (p_done) else $error("register op late");
  property p_rd; memOp |=> memRdReq_r && opBusy_r && memAddr_r == $past(memAddr); endproperty
  a_rd: assert property (p_rd) else $error("no byte read");
  property p_wait; opBusy_r && !memRdValid |=> opBusy_r && !opDone_r; endproperty
  a_wait: assert property (p_wait) else $error("ended before data");
  property p_end; opBusy_r && memRdValid |=> opDone_r && !opBusy_r; endproperty
  a_end: assert property (p_end) else $error("no end after data");
  property p_byte; regOp && opCode inside {[2:4]} |=> regWrite_r &&
    regResult_r[7:0] == $past(bExp); endproperty
  a_byte: assert property (p_byte) else $error("bad byte");
  property p_probe; regOp && opCode == 4'h5 |=> zeroWrite_r && !regWrite_r &&
    zeroResult_r == !$past(bSel); endproperty
  a_probe: assert property (p_probe) else $error("bad zero");
  property p_carry; regOp && opCode inside {[6:9]} |=> carryWrite_r &&
    carryResult_r == $past(cExp); endproperty
  a_carry: assert property (p_carry) else $error("bad carry");
  property p_rot; regOp && opCode < 4'h2 && opSize == 2'h0 |=>
    regResult_r[7:0] == $past(rExp) && carryResult_r == $past(rC); endproperty
  a_rot: assert property (p_rot) else $error("bad rotate");
endmodule
bind bmr_unit bmr_unit_props chk (.*);
`default_nettype wire

/* File: bmr_mem_model.sv */
// Purpose: Memory byte partner answering reads after lat cycles
// Assumes: lat is at least 1
// Notes: Data bus toggles when no answer is due
`timescale 1ns/1ps
`default_nettype none
module bmr_mem_model (
  input wire logic clk_sys,
  input wire logic [3:0] lat,
  input wire logic memRdReq_r,
  input wire logic memWrReq_r,
  input wire logic [15:0] memAddr_r,
  input wire logic [7:0] memWrData_r,
  output logic memRdValid,
  output logic [7:0] memRdData
);
  logic [7:0] mem [0:15];
  logic [3:0] cnt = 4'h0;
  initial memRdValid = 1'b0;
  initial memRdData = 8'h5A;
  // Stale byte is inverted so it never passes for data
  always @(posedge clk_sys) begin
    memRdValid <= 1'b0;
    memRdData <= ~memRdData;
    if (memWrReq_r) mem[memAddr_r[3:0]] <= memWrData_r;
    if (memRdReq_r) cnt <= lat;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    if (cnt == 4'h1) begin
      memRdValid <= 1'b1;
      memRdData <= mem[memAddr_r[3:0]];
    end
  end
endmodule
`default_nettype wire

/* File: tb_bit_manipulation_rotate_unit.sv */
// Purpose: Self-checking bench for bmr_unit
// Assumes: Inputs change on the falling edge
// Notes: One task per scenario
`timescale 1ns/1ps
`default_nettype none
`include "bmr_consts.vh"
module tb_bit_manipulation_rotate_unit;
  logic clk_sys = 0, sys_rst = 1, opValid = 0, opIsMem = 0, useRegBitNum = 0, carryIn = 0;
  logic [3:0] opCode = 0, lat = 1;
  logic [1:0] opSize = 0;
  logic [2:0] immBitNum = 0;
  logic [31:0] bitNumReg = 0, regOperand = 0, regResult_r;
  logic [15:0] memAddr = 0, memAddr_r;
  logic memRdValid, opBusy_r, opDone_r, regWrite_r, carryResult_r, carryWrite_r;
  logic zeroResult_r, zeroWrite_r, memRdReq_r, memWrReq_r;
  logic [7:0] memRdData, memWrData_r;
  int n_errors = 0, checks = 0;
  bmr_unit dut (.*);
  bmr_mem_model mdl (.*);
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (e !== g) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Fresh falling edge first, so opValid never moves twice in one step
  task automatic run(input logic [3:0] c, input logic [31:0] v, input logic ci);
    @(negedge clk_sys);
    opCode = c;
    regOperand = v;
    carryIn = ci;
    opValid = 1;
    @(negedge clk_sys) opValid = 0;
    for (int i = 0; i < 20 && opDone_r !== 1'b1; i++) @(negedge clk_sys);
    chk("opDone_r", 1, opDone_r);
  endtask
  task automatic t_rotate;
    logic [31:0] m, v, e;
    int w;
    v = 32'h4001_8102;
    for (int s = 0; s < 6; s++) begin
      w = 8 << (s / 2);
      m = (s > 3) ? 32'hFFFF_FFFF : (32'h1 << w) - 1;
      opSize = s / 2;
      run(s % 2, v, 1);
      e = s[0] ? (32'h1 << (w - 1)) | ((v & m) >> 1) : ((v << 1) | 32'h1) & m;
      chk("regResult_r", e, regResult_r);
      chk("carryResult_r", s[0] ? v[0] : v[w - 1], carryResult_r);
    end
    opSize = 0;
  endtask
  // Other source holds the opposite bit number
  task automatic t_bits;
    logic [31:0] v, e;
    v = 32'hA5C3_5A96;
    for (int k = 0; k < 48; k++) begin
      useRegBitNum = k[0];
      immBitNum = k[0] ? ~k[3:1] : k[3:1];
      bitNumReg = {29'h1, k[0] ? k[3:1] : ~k[3:1]};
      run(4'h2 + k[5:4], v, 0);
      e = 32'h1 << k[3:1];
      e = k[5] ? v ^ e : k[4] ? v & ~e : v | e;
      chk("regResult_r", e, regResult_r);
    end
  endtask
  // Register picks bit5 holding ~b, immediate bit3 holding b
  task automatic t_flags;
    logic b, e;
    useRegBitNum = 1;
    immBitNum = 3;
    bitNumReg = 5;
    for (int k = 0; k < 20; k++) begin
      b = k[0];
      run(4'h5 + k[4:2], {26'h0, ~b, 1'b0, b, 3'h0}, k[1]);
      e = k[4:2] == 0 ? b : (k[4:2] < 3 ? k[1] & ~b : k[1] | ~b);
      if (k[4:2] == 0) chk("zeroResult_r", e, zeroResult_r);
      else chk("carryResult_r", e, carryResult_r);
    end
  endtask
  task automatic t_mem;
    opIsMem = 1;
    useRegBitNum = 0;
    immBitNum = 1;
    memAddr = 16'h1234;
    lat = 6;
    mdl.mem[4] = 8'h3C;
    run(`BMR_OP_INV, 0, 0);
    chk("memWrData_r", 8'h3E, memWrData_r);
    chk("memWrReq_r", 1, memWrReq_r);
    chk("memAddr_r", 16'h1234, memAddr_r);
    lat = 1;
    // Probe sees bit1 of the written-back byte, so Z clear proves the write
    run(`BMR_OP_PROBE, 0, 0);
    chk("zeroResult_r", 0, zeroResult_r);
    chk("zeroWrite_r", 1, zeroWrite_r);
    chk("memWrReq_r", 0, memWrReq_r);
    opIsMem = 0;
  endtask
  // Reset in mid-read drops the operation; the late answer is ignored
  task automatic t_reset;
    @(negedge clk_sys);
    opIsMem = 1;
    lat = 4;
    opCode = `BMR_OP_FONE;
    opValid = 1;
    @(negedge clk_sys);
    opValid = 0;
    sys_rst = 1;
    @(negedge clk_sys);
    sys_rst = 0;
    chk("opBusy_r", 0, opBusy_r);
    chk("regResult_r", 0, regResult_r);
    chk("memAddr_r", 0, memAddr_r);
    repeat (5) begin
      @(negedge clk_sys);
      chk("opDone_r", 0, opDone_r);
      chk("memWrReq_r", 0, memWrReq_r);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk_sys);
    sys_rst = 0;
    t_rotate();
    t_bits();
    t_flags();
    t_mem();
    t_reset();
    close_out();
  end
  // Whole run is about 200 cycles
  initial begin
    #(25 * 2000);
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire
